/* File: hdl/rxim_ctrl.sv */
// Purpose: receiver interrupt masking and trigger-mode logic with its host registers
// Assumes: register port is the decoded byte port behind the serial host interface
// Notes: edge events latch until acknowledged or masked; level sources drive the output directly
// How it works
// - Bit 7 of the first mask register enables the channel-status CRC interrupt, reset 0 masks it.
// - Bit 6 of the first mask register enables the parity error interrupt, reset masked.
// - Bit 5 of the first mask register enables the validity interrupt, reset masked.
// - Bit 4 of the first mask register enables the biphase error interrupt, reset masked.
// - Bit 3 of the first mask register enables the sub-code change interrupt, reset masked.
// - Bit 2 of the first mask register enables the lock loss interrupt, reset masked.
// - Bit 1 of the first mask register enables the sub-code CRC interrupt, reset masked.
// - Bit 0 of the first mask register enables the buffer transfer interrupt, reset masked.
// - The second mask register holds only the output slip enable at bit 0; bits 7 to 1 read zero.
// - Each two-bit mode field means 00 rising edge (reset), 01 falling edge, 10 level, 11 reserved.
// - A status condition raises the interrupt only while its mask bit is enabled.
// - Output slip follows the port fed by the receiver, port a when both are.
`timescale 1ns/10ps
module rxim_ctrl #(
  parameter int NUM_SRC = rxim_pkg::RXIM_NUM_SRC
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [rxim_pkg::RXIM_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [rxim_pkg::RXIM_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [rxim_pkg::RXIM_DATA_W-1:0] reg_rdata_o,
  // receiver status conditions
  input wire logic cs_crc_err_i,
  input wire logic parity_err_i,
  input wire logic validity_err_i,
  input wire logic biphase_err_i,
  input wire logic subcode_change_i,
  input wire logic lock_loss_i,
  input wire logic subcode_crc_err_i,
  input wire logic buffer_xfer_i,
  // audio port slip sources
  input wire logic port_a_from_rx_i,
  input wire logic port_b_from_rx_i,
  input wire logic slip_a_i,
  input wire logic slip_b_i,
  // pending-event acknowledge, one bit per source
  input wire logic [8:0] irq_ack_i,
  output logic [8:0] irq_pending_o,
  output logic rx_irq_o
);

  import rxim_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] receiver_irq_enable_a;
  logic [0:0] receiver_irq_enable_b;
  logic [7:0] receiver_irq_trigger_a;
  logic [7:0] receiver_irq_trigger_b;
  logic [1:0] receiver_irq_trigger_c;

  logic wr_enable_a;
  logic wr_enable_b;
  logic wr_trigger_a;
  logic wr_trigger_b;
  logic wr_trigger_c;

  assign wr_enable_a = reg_wr_i && (reg_addr_i == RXIM_OFS_ENABLE_A);
  assign wr_enable_b = reg_wr_i && (reg_addr_i == RXIM_OFS_ENABLE_B);
  assign wr_trigger_a = reg_wr_i && (reg_addr_i == RXIM_OFS_TRIGGER_A);
  assign wr_trigger_b = reg_wr_i && (reg_addr_i == RXIM_OFS_TRIGGER_B);
  assign wr_trigger_c = reg_wr_i && (reg_addr_i == RXIM_OFS_TRIGGER_C);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      receiver_irq_enable_a <= RXIM_RST_ENABLE_A;
    end else if (wr_enable_a) begin
      receiver_irq_enable_a <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      receiver_irq_enable_b <= RXIM_RST_ENABLE_B;
    end else if (wr_enable_b) begin
      receiver_irq_enable_b <= reg_wdata_i[RXIM_BIT_OUTPUT_SLIP];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      receiver_irq_trigger_a <= RXIM_RST_TRIGGER_A;
    end else if (wr_trigger_a) begin
      receiver_irq_trigger_a <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      receiver_irq_trigger_b <= RXIM_RST_TRIGGER_B;
    end else if (wr_trigger_b) begin
      receiver_irq_trigger_b <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      receiver_irq_trigger_c <= RXIM_RST_TRIGGER_C;
    end else if (wr_trigger_c) begin
      receiver_irq_trigger_c <= reg_wdata_i[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-back, registered so the data output comes from a flop
  logic [7:0] next_rdata;

  always_comb begin
    case (reg_addr_i)
      RXIM_OFS_ENABLE_A: begin
        next_rdata = receiver_irq_enable_a;
      end
      RXIM_OFS_ENABLE_B: begin
        next_rdata = {7'h00, receiver_irq_enable_b};
      end
      RXIM_OFS_TRIGGER_A: begin
        next_rdata = receiver_irq_trigger_a;
      end
      RXIM_OFS_TRIGGER_B: begin
        next_rdata = receiver_irq_trigger_b;
      end
      RXIM_OFS_TRIGGER_C: begin
        next_rdata = {6'h00, receiver_irq_trigger_c};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source indices: slip first, then the first mask register from bit 0 up
  localparam int SRC_SLIP = 0;
  localparam int SRC_BUFFER_XFER = RXIM_BIT_BUFFER_XFER + 1;
  localparam int SRC_SUBCODE_CRC = RXIM_BIT_SUBCODE_CRC + 1;
  localparam int SRC_LOCK_LOSS = RXIM_BIT_LOCK_LOSS + 1;
  localparam int SRC_SUBCODE_CHG = RXIM_BIT_SUBCODE_CHG + 1;
  localparam int SRC_BIPHASE = RXIM_BIT_BIPHASE + 1;
  localparam int SRC_VALIDITY = RXIM_BIT_VALIDITY + 1;
  localparam int SRC_PARITY = RXIM_BIT_PARITY + 1;
  localparam int SRC_CS_CRC = RXIM_BIT_CS_CRC + 1;

  ////////////////////////////////////////////////////////////////////////////
  // named views of the mask and mode fields
  logic cs_crc_irq_enable;
  logic parity_err_irq_enable;
  logic validity_irq_enable;
  logic biphase_err_irq_enable;
  logic subcode_change_irq_enable;
  logic lock_loss_irq_enable;
  logic subcode_crc_irq_enable;
  logic buffer_xfer_irq_enable;
  logic output_slip_irq_enable;
  logic [1:0] subcode_change_trigger;
  logic [1:0] lock_loss_trigger;
  logic [1:0] subcode_crc_trigger;
  logic [1:0] buffer_xfer_trigger;
  logic [1:0] cs_crc_trigger;
  logic [1:0] parity_err_trigger;
  logic [1:0] validity_trigger;
  logic [1:0] biphase_err_trigger;
  logic [1:0] output_slip_trigger;

  assign cs_crc_irq_enable = receiver_irq_enable_a[RXIM_BIT_CS_CRC];
  assign parity_err_irq_enable = receiver_irq_enable_a[RXIM_BIT_PARITY];
  assign validity_irq_enable = receiver_irq_enable_a[RXIM_BIT_VALIDITY];
  assign biphase_err_irq_enable = receiver_irq_enable_a[RXIM_BIT_BIPHASE];
  assign subcode_change_irq_enable = receiver_irq_enable_a[RXIM_BIT_SUBCODE_CHG];
  assign lock_loss_irq_enable = receiver_irq_enable_a[RXIM_BIT_LOCK_LOSS];
  assign subcode_crc_irq_enable = receiver_irq_enable_a[RXIM_BIT_SUBCODE_CRC];
  assign buffer_xfer_irq_enable = receiver_irq_enable_a[RXIM_BIT_BUFFER_XFER];
  assign output_slip_irq_enable = receiver_irq_enable_b[RXIM_BIT_OUTPUT_SLIP];

  assign subcode_change_trigger = receiver_irq_trigger_a[RXIM_FLD_SUBCODE_CHG +: 2];
  assign lock_loss_trigger = receiver_irq_trigger_a[RXIM_FLD_LOCK_LOSS +: 2];
  assign subcode_crc_trigger = receiver_irq_trigger_a[RXIM_FLD_SUBCODE_CRC +: 2];
  assign buffer_xfer_trigger = receiver_irq_trigger_a[RXIM_FLD_BUFFER_XFER +: 2];
  // second and third mode registers share the first one's encoding
  assign cs_crc_trigger = receiver_irq_trigger_b[RXIM_FLD_CS_CRC +: 2];
  assign parity_err_trigger = receiver_irq_trigger_b[RXIM_FLD_PARITY +: 2];
  assign validity_trigger = receiver_irq_trigger_b[RXIM_FLD_VALIDITY +: 2];
  assign biphase_err_trigger = receiver_irq_trigger_b[RXIM_FLD_BIPHASE +: 2];
  assign output_slip_trigger = receiver_irq_trigger_c[RXIM_FLD_OUTPUT_SLIP +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // source vectors, indexed by the SRC_ constants above
  logic output_slip_status;
  logic [8:0] status_vec;
  logic [8:0] enable_vec;
  logic [17:0] mode_vec;

  rxim_slip_sel u_slip_sel (
    .port_a_from_rx_i(port_a_from_rx_i),
    .port_b_from_rx_i(port_b_from_rx_i),
    .slip_a_i(slip_a_i),
    .slip_b_i(slip_b_i),
    .output_slip_status_o(output_slip_status)
  );

  assign status_vec[SRC_SLIP] = output_slip_status;
  assign status_vec[SRC_BUFFER_XFER] = buffer_xfer_i;
  assign status_vec[SRC_SUBCODE_CRC] = subcode_crc_err_i;
  assign status_vec[SRC_LOCK_LOSS] = lock_loss_i;
  assign status_vec[SRC_SUBCODE_CHG] = subcode_change_i;
  assign status_vec[SRC_BIPHASE] = biphase_err_i;
  assign status_vec[SRC_VALIDITY] = validity_err_i;
  assign status_vec[SRC_PARITY] = parity_err_i;
  assign status_vec[SRC_CS_CRC] = cs_crc_err_i;

  assign enable_vec[SRC_SLIP] = output_slip_irq_enable;
  assign enable_vec[SRC_BUFFER_XFER] = buffer_xfer_irq_enable;
  assign enable_vec[SRC_SUBCODE_CRC] = subcode_crc_irq_enable;
  assign enable_vec[SRC_LOCK_LOSS] = lock_loss_irq_enable;
  assign enable_vec[SRC_SUBCODE_CHG] = subcode_change_irq_enable;
  assign enable_vec[SRC_BIPHASE] = biphase_err_irq_enable;
  assign enable_vec[SRC_VALIDITY] = validity_irq_enable;
  assign enable_vec[SRC_PARITY] = parity_err_irq_enable;
  assign enable_vec[SRC_CS_CRC] = cs_crc_irq_enable;

  // source i takes mode bits [2i+1:2i]
  assign mode_vec[2*SRC_SLIP +: 2] = output_slip_trigger;
  assign mode_vec[2*SRC_BUFFER_XFER +: 2] = buffer_xfer_trigger;
  assign mode_vec[2*SRC_SUBCODE_CRC +: 2] = subcode_crc_trigger;
  assign mode_vec[2*SRC_LOCK_LOSS +: 2] = lock_loss_trigger;
  assign mode_vec[2*SRC_SUBCODE_CHG +: 2] = subcode_change_trigger;
  assign mode_vec[2*SRC_BIPHASE +: 2] = biphase_err_trigger;
  assign mode_vec[2*SRC_VALIDITY +: 2] = validity_trigger;
  assign mode_vec[2*SRC_PARITY +: 2] = parity_err_trigger;
  assign mode_vec[2*SRC_CS_CRC +: 2] = cs_crc_trigger;

  ////////////////////////////////////////////////////////////////////////////
  // detection and pending flags
  logic [8:0] event_vec;
  logic [8:0] level_vec;
  logic [8:0] pending;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      rxim_trig_det u_det (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .status_i(status_vec[gi]),
        .mode_i(mode_vec[2*gi +: 2]),
        .enable_i(enable_vec[gi]),
        .event_o(event_vec[gi]),
        .level_o(level_vec[gi])
      );

      logic set_pend;
      logic clr_pend;

      // a fresh edge in the ack cycle survives: set beats clear
      assign set_pend = event_vec[gi];
      // masking drops a stale edge so it cannot fire later
      assign clr_pend = irq_ack_i[gi] | ~enable_vec[gi];

      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          pending[gi] <= 1'b0;
        end else if (set_pend) begin
          pending[gi] <= 1'b1;
        end else if (clr_pend) begin
          pending[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_pending_o = pending;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt output
  logic edge_active;
  logic level_active;
  logic next_rx_irq;

  // pending clears on mask one edge late, the and hides it in between
  assign edge_active = |(pending & enable_vec);
  assign level_active = |level_vec;
  assign next_rx_irq = edge_active | level_active;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rx_irq_o <= 1'b0;
    end else begin
      rx_irq_o <= next_rx_irq;
    end
  end

endmodule : rxim_ctrl

/* File: hdl/rxim_pkg.sv */
// Purpose: shared constants for the receiver interrupt mask and trigger-mode block
// Assumes: 8-bit register port, byte addresses as printed
// Notes: source index 0 is output slip, 1..8 follow the first mask register bits 0..7
package rxim_pkg;

  localparam int RXIM_NUM_SRC = 9;
  localparam int RXIM_ADDR_W = 8;
  localparam int RXIM_DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] RXIM_OFS_ENABLE_A = 8'h16;
  localparam logic [7:0] RXIM_OFS_ENABLE_B = 8'h17;
  localparam logic [7:0] RXIM_OFS_TRIGGER_A = 8'h18;
  localparam logic [7:0] RXIM_OFS_TRIGGER_B = 8'h19;
  localparam logic [7:0] RXIM_OFS_TRIGGER_C = 8'h1a;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RXIM_RST_ENABLE_A = 8'h00;
  localparam logic [0:0] RXIM_RST_ENABLE_B = 1'h0;
  localparam logic [7:0] RXIM_RST_TRIGGER_A = 8'h00;
  localparam logic [7:0] RXIM_RST_TRIGGER_B = 8'h00;
  localparam logic [1:0] RXIM_RST_TRIGGER_C = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // field positions, first mask register
  localparam int RXIM_BIT_CS_CRC = 7;
  localparam int RXIM_BIT_PARITY = 6;
  localparam int RXIM_BIT_VALIDITY = 5;
  localparam int RXIM_BIT_BIPHASE = 4;
  localparam int RXIM_BIT_SUBCODE_CHG = 3;
  localparam int RXIM_BIT_LOCK_LOSS = 2;
  localparam int RXIM_BIT_SUBCODE_CRC = 1;
  localparam int RXIM_BIT_BUFFER_XFER = 0;
  // second mask register
  localparam int RXIM_BIT_OUTPUT_SLIP = 0;
  // first mode register field low bits
  localparam int RXIM_FLD_SUBCODE_CHG = 6;
  localparam int RXIM_FLD_LOCK_LOSS = 4;
  localparam int RXIM_FLD_SUBCODE_CRC = 2;
  localparam int RXIM_FLD_BUFFER_XFER = 0;
  // second mode register field low bits
  localparam int RXIM_FLD_CS_CRC = 6;
  localparam int RXIM_FLD_PARITY = 4;
  localparam int RXIM_FLD_VALIDITY = 2;
  localparam int RXIM_FLD_BIPHASE = 0;
  // third mode register
  localparam int RXIM_FLD_OUTPUT_SLIP = 0;

  ////////////////////////////////////////////////////////////////////////////
  // trigger mode encodings
  typedef enum logic [1:0] {
    RXIM_TRIG_RISE = 2'b00,
    RXIM_TRIG_FALL = 2'b01,
    RXIM_TRIG_LEVEL = 2'b10,
    RXIM_TRIG_RSVD = 2'b11
  } rxim_trig_t;

endpackage : rxim_pkg

/* File: hdl/rxim_slip_sel.sv */
// Purpose: picks which audio port's slip flag feeds the receiver output slip source
// Assumes: slip flags are meaningful only for a port sourced by the receiver
// Notes: port a wins when both ports take receiver data
`timescale 1ns/10ps
module rxim_slip_sel (
  input wire logic port_a_from_rx_i,
  input wire logic port_b_from_rx_i,
  input wire logic slip_a_i,
  input wire logic slip_b_i,
  output logic output_slip_status_o
);

  always_comb begin
    if (port_a_from_rx_i) begin
      output_slip_status_o = slip_a_i;
    end else if (port_b_from_rx_i) begin
      output_slip_status_o = slip_b_i;
    end else begin
      output_slip_status_o = 1'b0;
    end
  end

endmodule : rxim_slip_sel

/* File: hdl/rxim_trig_det.sv */
// Purpose: per-source trigger detector (edge or level) gated by its enable
// Assumes: status comes from logic on core_clk_i, no synchroniser needed
// Notes: previous-status flop tracks even while masked so enabling never fakes an edge
`timescale 1ns/10ps
module rxim_trig_det (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic status_i,
  input wire logic [1:0] mode_i,
  input wire logic enable_i,
  output logic event_o,
  output logic level_o
);

  import rxim_pkg::*;

  logic status_q;
  logic rise;
  logic fall;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      status_q <= 1'b0;
    end else begin
      status_q <= status_i;
    end
  end

  assign rise = status_i & ~status_q;
  assign fall = ~status_i & status_q;

  always_comb begin
    event_o = 1'b0;
    level_o = 1'b0;
    if (enable_i) begin
      case (mode_i)
        RXIM_TRIG_RISE: begin
          event_o = rise;
        end
        RXIM_TRIG_FALL: begin
          event_o = fall;
        end
        RXIM_TRIG_LEVEL: begin
          level_o = status_i;
        end
        default: begin
          // reserved code: host must not write it, so it stays silent
          event_o = 1'b0;
          level_o = 1'b0;
        end
      endcase
    end
  end

endmodule : rxim_trig_det

/* File: verif/receiver_irq_mask_mode_tb.sv */
// Purpose: self-checking bench for rxim_ctrl
// Assumes: status sources driven directly in the core clock domain
// Notes: checks are taken after a few settle cycles, not on exact latency
`timescale 1ns/10ps
module receiver_irq_mask_mode_tb;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr, wdata, rdata, q;
  logic wr, rd, irq;
  logic pa = 1'b1, pb = 1'b0, sb = 1'b0;
  logic [8:0] stat = 9'h000, ack = 9'h000, pend;
  int n_mismatch = 0, compares = 0, seed = 26574;
  int rm [6];
  always #5 core_clk_i = ~core_clk_i;
  rxim_host u_host (.core_clk_i, .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata),
    .reg_rd_o(rd));
  rxim_ctrl u_dut (.core_clk_i, .srst_i, .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .cs_crc_err_i(stat[8]), .parity_err_i(stat[7]), .validity_err_i(stat[6]),
    .biphase_err_i(stat[5]), .subcode_change_i(stat[4]), .lock_loss_i(stat[3]), .subcode_crc_err_i(stat[2]),
    .buffer_xfer_i(stat[1]), .port_a_from_rx_i(pa), .port_b_from_rx_i(pb), .slip_a_i(stat[0]), .slip_b_i(sb),
    .irq_ack_i(ack), .irq_pending_o(pend), .rx_irq_o(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : wt
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // source 0 is slip, 1..8 follow mask bits 0..7
  task automatic src_test(input int i, input int m);
    logic [7:0] ea, ma;
    int ep, bp;
    ea = (i == 0) ? 8'h17 : 8'h16;
    ma = (i == 0) ? 8'h1a : ((i < 5) ? 8'h18 : 8'h19);
    ep = (i == 0) ? 0 : i - 1;
    bp = (i == 0) ? 0 : ((i - 1) % 4) * 2;
    stat[i] = (m == 1);
    u_host.xfer(1'b1, ma, 8'(m << bp), q);
    u_host.xfer(1'b1, ea, 8'(1 << ep), q);
    wt(3);
    stat[i] = (m != 1);
    wt(3);
    chk({pend, irq}, {((m == 2) ? 9'h000 : 9'(1 << i)), 1'b1}, "source raised");
    stat[i] = (m == 1);
    ack = 9'(1 << i);
    wt(1);
    ack = 9'h000;
    wt(3);
    chk({pend, irq}, 10'h000, "source cleared");
    u_host.xfer(1'b1, ea, 8'h00, q);
    stat[i] = (m != 1);
    wt(3);
    chk({pend, irq}, 10'h000, "masked source");
    stat[i] = 1'b0;
  endtask : src_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wt(12);
    srst_i = 1'b0;
    for (int k = 0; k < 6; k++) begin
      rm[k] = $random(seed) & 8'hff;
      // reserved code 11 becomes 10 in mode bytes
      if (k >= 2) rm[k] = (rm[k] & 8'haa) | (rm[k] & 8'h55 & ~((rm[k] & 8'haa) >> 1));
      u_host.xfer(1'b1, 8'(8'h16 + k), 8'(rm[k]), q);
    end
    for (int k = 0; k < 6; k++) begin
      u_host.xfer(1'b0, 8'(8'h16 + k), 8'h00, q);
      chk({2'b00, q}, 10'((k == 1) ? rm[k] & 1 : (k == 4) ? rm[k] & 3 : (k == 5) ? 0 : rm[k]), "readback");
    end
    srst_i = 1'b1;
    wt(2);
    srst_i = 1'b0;
    for (int k = 0; k < 6; k++) begin
      u_host.xfer(1'b0, 8'(8'h16 + k), 8'h00, q);
      chk({2'b00, q}, 10'h000, "reset value");
    end
    $display("register test done");
    for (int i = 0; i < 9; i++) begin
      for (int m = 0; m < 3; m++) src_test(i, m);
    end
    $display("source test done");
    u_host.xfer(1'b1, 8'h1a, 8'h02, q);
    u_host.xfer(1'b1, 8'h17, 8'h01, q);
    for (int c = 0; c < 16; c++) begin
      {pa, pb, stat[0], sb} = 4'(c);
      wt(3);
      chk({9'h000, irq}, {9'h000, (pa ? stat[0] : (pb & sb))}, "slip source");
    end
    $display("slip test done");
    stop_test();
  end
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule : receiver_irq_mask_mode_tb
bind rxim_ctrl rxim_chk u_chk (.core_clk_i, .srst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
  .parity_err_i, .lock_loss_i, .buffer_xfer_i, .port_a_from_rx_i, .slip_a_i, .irq_ack_i, .irq_pending_o, .rx_irq_o);

/* File: verif/rxim_ctrl_assertions.sv */
// Purpose: port-level checks for rxim_ctrl
// Assumes: shadow copies follow host writes exactly
// Notes: shadows keep the checks free of hierarchical peeks
`timescale 1ns/10ps
module rxim_chk (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic parity_err_i,
  input wire logic lock_loss_i,
  input wire logic buffer_xfer_i,
  input wire logic port_a_from_rx_i,
  input wire logic slip_a_i,
  input wire logic [8:0] irq_ack_i,
  input wire logic [8:0] irq_pending_o,
  input wire logic rx_irq_o
);
  logic [7:0] sh [5];
  always_ff @(posedge core_clk_i) begin
    for (int k = 0; k < 5; k++) begin
      if (srst_i) begin
        sh[k] <= 8'h00;
      end else if (reg_wr_i && reg_addr_i == 8'(8'h16 + k)) begin
        sh[k] <= reg_wdata_i;
      end
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////////////////
  // writes in the same cycle are excluded: next-value use is a design choice
  sequence par_rise; $rose(parity_err_i) && sh[0][6] && sh[3][5:4] == 2'b00 && !reg_wr_i; endsequence
  sequence lock_fall; $fell(lock_loss_i) && sh[0][2] && sh[2][5:4] == 2'b01 && !reg_wr_i; endsequence
  rst_clr_a: assert property (disable iff (1'b0) srst_i |=> {reg_rdata_o, irq_pending_o, rx_irq_o} == 18'h0)
    else $error("state not cleared by reset");
  rd_en_a: assert property (reg_rd_i && reg_addr_i == 8'h16 |=> reg_rdata_o == $past(sh[0]))
    else $error("mask a readback wrong");
  rd_slip_a: assert property (reg_rd_i && reg_addr_i == 8'h17 |=> reg_rdata_o == {7'h00, $past(sh[1][0])})
    else $error("mask b readback wrong");
  rd_mode_a: assert property (reg_rd_i && reg_addr_i == 8'h18 |=> reg_rdata_o == $past(sh[2]))
    else $error("mode a readback wrong");
  rise_pend_a: assert property (par_rise |=> irq_pending_o[7])
    else $error("parity rise not latched");
  fall_pend_a: assert property (lock_fall |=> irq_pending_o[3])
    else $error("lock loss fall not latched");
  pend_irq_a: assert property (irq_pending_o[7] && sh[0][6] && !irq_ack_i[7] && !reg_wr_i |=> rx_irq_o)
    else $error("pending parity without irq");
  lvl_irq_a: assert property (sh[0][0] && sh[2][1:0] == 2'b10 && buffer_xfer_i && !reg_wr_i |=> rx_irq_o)
    else $error("level source without irq");
  quiet_irq_a: assert property ((sh[0] == 8'h00 && !sh[1][0])[*3] |-> !rx_irq_o)
    else $error("irq with all sources masked");
  slip_irq_a: assert property (sh[1][0] && sh[4][1:0] == 2'b10 && port_a_from_rx_i && slip_a_i |=> rx_irq_o)
    else $error("port a slip without irq");
  for (genvar k = 0; k < 8; k++) begin : g_msk
    mask_clr_a: assert property ((!sh[0][k])[*2] |-> !irq_pending_o[k+1])
      else $error("pending on masked source");
  end
endmodule : rxim_chk

/* File: verif/rxim_host.sv */
// Purpose: host model on the decoded register port
// Assumes: one byte per transfer, strobes one cycle
// Notes: released address and data lines show the inverse so stale values never look valid
`timescale 1ns/10ps
module rxim_host (
  input wire logic core_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o
);
  initial {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = 18'h0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk_i) #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = w;
    reg_rd_o = !w;
    @(posedge core_clk_i) #1;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
    q = reg_rdata_i;
  endtask : xfer
endmodule : rxim_host
